/* File: inc/tcm_defs.svh */
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

// register byte addresses
`define TCM_OFS_A_LOW   32'h4000_0010
`define TCM_OFS_A_HIGH  32'h4000_0014
`define TCM_OFS_B_LOW   32'h4000_0018
`define TCM_OFS_B_HIGH  32'h4000_001C
`define TCM_OFS_C_LOW   32'h4000_0020
`define TCM_OFS_C_HIGH  32'h4000_0024
`define TCM_OFS_IEN     32'h4000_0028
`define TCM_OFS_STAT    32'h4000_002C
`define TCM_OFS_MASK    32'h4000_0034

// reset values
`define TCM_RST_A_LOW   16'h1FFF
`define TCM_RST_B_LOW   16'h2FFF
`define TCM_RST_C_LOW   16'h3FFF
`define TCM_RST_HIGH    16'h0000
`define TCM_RST_IEN     4'h0
`define TCM_RST_MASK    4'h0

// source bit positions in enable, status and mask
`define TCM_BIT_A       0
`define TCM_BIT_B       1
`define TCM_BIT_C       2
`define TCM_BIT_ROLL    3
`define TCM_NUM_SRC     4
`define TCM_NUM_FIELD   3
// status bits that a read clears
`define TCM_RD_CLR_MASK 4'h7

`endif

/* File: inc/tcm_pkg.sv */
package tcm_pkg;

   // one bus request as seen by the slave
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be;
   } tcm_bus_req_t;

   // one compare channel: gate and target
   typedef struct packed {
      logic        en;
      logic [31:0] target;
   } tcm_cmp_t;

endpackage : tcm_pkg

/* File: hdl/tcm_cmp_unit.sv */
`timescale 1ns/1ps
module tcm_cmp_unit #(
   parameter int WIDTH = 32
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             enable_i,
   input  wire logic [WIDTH-1:0] counter_i,
   input  wire logic [WIDTH-1:0] target_i,
   output logic                  hit_o
);

   generate
      if (WIDTH < 2) begin : g_chk
         $error("tcm_cmp_unit: WIDTH too small");
      end
   endgenerate

   logic eq;
   logic eq_q;

   // gated full-width equality; disabled means no compare at all
   assign eq = enable_i && (counter_i == target_i); // R10 R16

   // counter may hold one value for many clocks, so fire on the first only
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         eq_q  <= 1'b0;
         hit_o <= 1'b0;
      end else begin
         eq_q  <= eq;
         hit_o <= eq && !eq_q;
      end
   end

   hit_cause_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R16
      hit_o |-> $past(enable_i) && ($past(counter_i) == $past(target_i)))
      else $error("hit without enabled equality");

endmodule : tcm_cmp_unit

/* File: hdl/tcm_flag_bank.sv */
`timescale 1ns/1ps
module tcm_flag_bank #(
   parameter int N = 4
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [N-1:0] set_i,
   input  wire logic [N-1:0] clr_i,
   output logic      [N-1:0] flag_o
);

   generate
      if (N < 1) begin : g_chk
         $error("tcm_flag_bank: N must be positive");
      end
   endgenerate

   // sticky flags; a set in the clearing cycle wins so no event is lost
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_flag
         always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               flag_o[gi] <= 1'b0;
            end else begin
               flag_o[gi] <= set_i[gi] || (flag_o[gi] && !clr_i[gi]);
            end
         end
      end
   endgenerate

   set_wins_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      set_i[0] |=> flag_o[0])
      else $error("set lost against clear");

endmodule : tcm_flag_bank

/* File: hdl/tcm_top.sv */
// Functional notes
// R1: software clears enable bit 0 before changing the upper half of field A and restores it after.
// R2: the lower half of field A resets to 0x1FFF and forms the low half of the A compare value.
// R3: field B is two 16-bit halves, lower resetting to 0x2FFF and upper to 0x0000.
// R4: software clears enable bit 1 before writing either half of field B and restores it after.
// R5: field C is two 16-bit halves, lower resetting to 0x3FFF and upper to 0x0000.
// R6: outside free-running mode the counter is reloaded once it reaches field C.
// R7: in periodic mode software writes field C only while the timer is disabled.
// R8: in free-running mode writes to field C are taken while the counter runs.
// R9: software clears enable bit 2 before writing field C and may restore it after.
// R10: a clear enable bit stops that field's compare and keeps its status flag from setting.
// R11: enable bits 0, 1 and 2 raise the interrupt on a match with field A, B or C, all off at reset; the code also needs the matching mask bit set.
// R12: enable bit 3 raises the interrupt on rollover, only in free-running mode, off at reset; the code also needs mask bit 3 set.
// R13: software writes zeros to enable bits 15 to 4.
// R14: rollover is the counter at all ones counting up or all zeros counting down.
// R15: the A, B and C match flags clear when software reads them.
// R16: a match is full 32-bit equality of the counter with the upper and lower halves joined.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "tcm_defs.svh"
module tcm_top (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [31:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [31:0] counter_value_i,
   input  wire logic        free_run_i,
   input  wire logic        count_down_i,
   output logic             counter_reload_o,
   output logic             irq_o
);

   localparam int NF = `TCM_NUM_FIELD;
   localparam int NS = `TCM_NUM_SRC;

   localparam logic [31:0] LO_OFS [NF] = '{`TCM_OFS_A_LOW, `TCM_OFS_B_LOW, `TCM_OFS_C_LOW};
   localparam logic [31:0] HI_OFS [NF] = '{`TCM_OFS_A_HIGH, `TCM_OFS_B_HIGH, `TCM_OFS_C_HIGH};
   localparam logic [15:0] LO_RST [NF] = '{`TCM_RST_A_LOW, `TCM_RST_B_LOW, `TCM_RST_C_LOW};

   tcm_pkg::tcm_bus_req_t bus;
   tcm_pkg::tcm_cmp_t     cmp [NS];

   logic [15:0]    cmp_lo [NF];
   logic [15:0]    cmp_hi [NF];
   logic [31:0]    field  [NF];
   logic [NS-1:0]  ien;
   logic [NS-1:0]  mask;
   logic [NS-1:0]  hits;
   logic [NS-1:0]  flags;
   logic [NS-1:0]  clr;
   logic [31:0]    next_rdata;
   logic           wr_go;
   logic           rd_go;
   logic           eq_c;
   logic           eq_c_q;

   // byte lanes 0 and 1 carry the 16-bit registers
   function automatic logic [15:0] be_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [3:0]  be);
      be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : be_merge

   // request bundle
   assign bus.rd    = avs_read_i;
   assign bus.wr    = avs_write_i;
   assign bus.addr  = avs_address_i;
   assign bus.wdata = avs_writedata_i;
   assign bus.be    = avs_byteenable_i;

   // a request completes at the edge where waitrequest is seen low
   assign wr_go = bus.wr && !avs_waitrequest_o;
   assign rd_go = bus.rd && !avs_waitrequest_o;

   // one wait cycle per access gives time to register read data
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !((bus.rd || bus.wr) && avs_waitrequest_o);
      end
   end

   // compare field halves; writes taken in any mode, the counter keeps running
   genvar gi;
   generate
      for (gi = 0; gi < NF; gi++) begin : g_field
         always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               cmp_lo[gi] <= LO_RST[gi]; // R2 R3 R5
               cmp_hi[gi] <= `TCM_RST_HIGH; // R3 R5
            end else if (wr_go) begin
               if (bus.addr == LO_OFS[gi]) begin
                  cmp_lo[gi] <= be_merge(cmp_lo[gi], bus.wdata[15:0], bus.be); // R8
               end
               if (bus.addr == HI_OFS[gi]) begin
                  cmp_hi[gi] <= be_merge(cmp_hi[gi], bus.wdata[15:0], bus.be); // R8
               end
            end
         end
         assign field[gi] = {cmp_hi[gi], cmp_lo[gi]}; // R2 R3 R5 R16
      end
   endgenerate

   // enable and mask; bits above the four sources are not stored
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ien  <= `TCM_RST_IEN; // R11 R12
         mask <= `TCM_RST_MASK;
      end else if (wr_go && bus.be[0]) begin
         if (bus.addr == `TCM_OFS_IEN) begin
            ien <= bus.wdata[NS-1:0];
         end
         if (bus.addr == `TCM_OFS_MASK) begin
            mask <= bus.wdata[NS-1:0];
         end
      end
   end

   // channel setup: three fields plus the rollover end value
   always_comb begin
      cmp[`TCM_BIT_A] = '{en: ien[`TCM_BIT_A], target: field[0]}; // R10
      cmp[`TCM_BIT_B] = '{en: ien[`TCM_BIT_B], target: field[1]}; // R10
      cmp[`TCM_BIT_C] = '{en: ien[`TCM_BIT_C], target: field[2]}; // R10
      cmp[`TCM_BIT_ROLL].en     = ien[`TCM_BIT_ROLL] && free_run_i; // R12
      cmp[`TCM_BIT_ROLL].target = count_down_i ? 32'h0000_0000 : 32'hFFFF_FFFF; // R14
   end

   // one comparator per source
   generate
      for (gi = 0; gi < NS; gi++) begin : g_cmp
         tcm_cmp_unit #(
            .WIDTH (32)
         ) u_cmp (
            .core_clk_i (core_clk_i),
            .rst_n_i    (rst_n_i),
            .enable_i   (cmp[gi].en),
            .counter_i  (counter_value_i),
            .target_i   (cmp[gi].target),
            .hit_o      (hits[gi])
         );
      end
   endgenerate

   // clears: write one to status, or read, which drops only the A, B and C bits returned
   always_comb begin
      clr = '0;
      if (wr_go && bus.be[0] && bus.addr == `TCM_OFS_STAT) begin
         clr = bus.wdata[NS-1:0];
      end
      if (rd_go && bus.addr == `TCM_OFS_STAT) begin
         clr = clr | (avs_readdata_o[NS-1:0] & `TCM_RD_CLR_MASK); // R15
      end
   end

   tcm_flag_bank #(
      .N (NS)
   ) u_flags (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .set_i      (hits),
      .clr_i      (clr),
      .flag_o     (flags)
   );

   // level interrupt from unmasked flags
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(flags & mask); // R11 R12
      end
   end

   // periodic reload request, independent of the interrupt enables
   assign eq_c = (counter_value_i == field[2]);

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         eq_c_q           <= 1'b0;
         counter_reload_o <= 1'b0;
      end else begin
         eq_c_q           <= eq_c;
         counter_reload_o <= !free_run_i && eq_c && !eq_c_q; // R6
      end
   end

   // read mux; unmapped addresses read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (bus.addr)
         `TCM_OFS_A_LOW:  next_rdata[15:0] = cmp_lo[0];
         `TCM_OFS_A_HIGH: next_rdata[15:0] = cmp_hi[0];
         `TCM_OFS_B_LOW:  next_rdata[15:0] = cmp_lo[1];
         `TCM_OFS_B_HIGH: next_rdata[15:0] = cmp_hi[1];
         `TCM_OFS_C_LOW:  next_rdata[15:0] = cmp_lo[2];
         `TCM_OFS_C_HIGH: next_rdata[15:0] = cmp_hi[2];
         `TCM_OFS_IEN:    next_rdata[NS-1:0] = ien;
         `TCM_OFS_STAT:   next_rdata[NS-1:0] = flags;
         `TCM_OFS_MASK:   next_rdata[NS-1:0] = mask;
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   // read data held from the wait cycle through completion
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (bus.rd && avs_waitrequest_o) begin
         avs_readdata_o <= next_rdata;
      end
   end

   // checks
   a_reset_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R2
      $rose(rst_n_i) |-> cmp_lo[0] == `TCM_RST_A_LOW)
      else $error("field A low reset value wrong");

   b_reset_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R3
      $rose(rst_n_i) |-> field[1] == {`TCM_RST_HIGH, `TCM_RST_B_LOW})
      else $error("field B reset value wrong");

   c_reset_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
      $rose(rst_n_i) |-> field[2] == {`TCM_RST_HIGH, `TCM_RST_C_LOW} && ien == 4'h0)
      else $error("field C or enable reset value wrong");

   reload_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
      (!free_run_i && eq_c && !eq_c_q) |=> counter_reload_o ##1 !counter_reload_o)
      else $error("reload not one pulse at field C");

   c_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R8
      (wr_go && bus.addr == `TCM_OFS_C_LOW && bus.be[1:0] == 2'b11)
      |=> cmp_lo[2] == $past(bus.wdata[15:0]))
      else $error("field C write not taken");

   gate_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R10
      $rose(flags[`TCM_BIT_A]) |-> $past(ien[`TCM_BIT_A], 2))
      else $error("flag A set while disabled");

   irq_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R11
      |(flags & mask) |=> irq_o)
      else $error("interrupt missing for unmasked flag");

   roll_mode_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R12
      $rose(flags[`TCM_BIT_ROLL]) |-> $past(free_run_i, 2) && $past(ien[`TCM_BIT_ROLL], 2))
      else $error("rollover flag outside free run");

   roll_value_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R14
      hits[`TCM_BIT_ROLL] |-> ($past(count_down_i) ? $past(counter_value_i) == 32'h0000_0000
                                                 : $past(counter_value_i) == 32'hFFFF_FFFF))
      else $error("rollover at wrong counter value");

   read_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
      (rd_go && bus.addr == `TCM_OFS_STAT && avs_readdata_o[`TCM_BIT_B] && !hits[`TCM_BIT_B])
      |=> !flags[`TCM_BIT_B])
      else $error("flag B not cleared by read");

   match_value_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R16
      hits[`TCM_BIT_C] |-> $past(counter_value_i) == $past(field[2]))
      else $error("match C without full equality");

   bus_answer_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ((bus.rd || bus.wr) && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not after one wait cycle");

   // read data comes from the mux as it stood in the wait cycle
   read_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (bus.rd && avs_waitrequest_o) |=> avs_readdata_o == $past(next_rdata))
      else $error("read data not taken in the wait cycle");

   // the level must fall too, or a serviced source keeps the line stuck
   irq_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R11
      !(|(flags & mask)) |=> !irq_o)
      else $error("interrupt without unmasked flag");

   ien_store_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R11
      (wr_go && bus.be[0] && bus.addr == `TCM_OFS_IEN)
      |=> ien == $past(bus.wdata[NS-1:0]))
      else $error("enable write not taken");

   gate_flag_b_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R10
      $rose(flags[`TCM_BIT_B]) |-> $past(ien[`TCM_BIT_B], 2))
      else $error("flag B set while disabled");

   gate_flag_c_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R10
      $rose(flags[`TCM_BIT_C]) |-> $past(ien[`TCM_BIT_C], 2))
      else $error("flag C set while disabled");

   free_reload_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
      free_run_i |=> !counter_reload_o)
      else $error("reload pulse in free-running mode");

   // write one to the rollover bit is its only clear
   roll_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R12
      (wr_go && bus.be[0] && bus.addr == `TCM_OFS_STAT && bus.wdata[`TCM_BIT_ROLL]
       && !hits[`TCM_BIT_ROLL]) |=> !flags[`TCM_BIT_ROLL])
      else $error("rollover flag not cleared by write");

   irq_seen_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $rose(irq_o));
   reload_seen_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) counter_reload_o);
   rd_clear_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      rd_go && bus.addr == `TCM_OFS_STAT && avs_readdata_o[0]);
   roll_seen_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      hits[`TCM_BIT_ROLL]);
   masked_flag_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      flags[`TCM_BIT_B] && !mask[`TCM_BIT_B] && !irq_o);

endmodule : tcm_top

/* File: verif/tcm_tb.sv */
`timescale 1ns/1ps
`include "tcm_defs.svh"
module testbench;
   localparam logic [31:0] IDLE_CNT = 32'h5555_0000;
   logic        core_clk_i       = 1'b0;
   logic        rst_n_i          = 1'b0;
   logic [31:0] avs_address_i    = 32'h0000_0000;
   logic        avs_read_i       = 1'b0;
   logic        avs_write_i      = 1'b0;
   logic [31:0] avs_writedata_i  = 32'h0000_0000;
   logic [3:0]  avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic [31:0] counter_value_i  = IDLE_CNT;
   logic        free_run_i       = 1'b0;
   logic        count_down_i     = 1'b0;
   logic        counter_reload_o;
   logic        irq_o;
   int          n_mismatch = 0;
   int          n_tests    = 0;
   int          n_cycle    = 0;
   int          n_reload   = 0;
   int          exp_reload = 0;
   integer      seed       = 32'hEC8EB42B;
   logic [15:0] mdl [0:9];
   logic [3:0]  ex_st      = 4'h0;
   logic [31:0] rd_val;

   // free-running bench clock, 4 ns period
   always #2 core_clk_i = ~core_clk_i;

   tcm_top i_dut (
      .core_clk_i        (core_clk_i),
      .rst_n_i           (rst_n_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .counter_value_i   (counter_value_i),
      .free_run_i        (free_run_i),
      .count_down_i      (count_down_i),
      .counter_reload_o  (counter_reload_o),
      .irq_o             (irq_o)
   );

   // reload pulses counted per edge, so a stretched pulse shows as extra counts
   always @(posedge core_clk_i) begin
      n_cycle <= n_cycle + 1;
      if (counter_reload_o === 1'b1) n_reload <= n_reload + 1;
      if (n_cycle > 6000) begin
         n_mismatch = n_mismatch + 1;
         test_done();
      end
   end

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: read %h, model %h", $time, got, exp);
      end
   endtask : cmp_reg

   task automatic cmp_flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: flag %b, model %b", $time, got, exp);
      end
   endtask : cmp_flag

   task automatic cmp_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         n_mismatch++;
         $display("unexpected at %0t: pulse count %0d, model %0d", $time, got, exp);
      end
   endtask : cmp_cnt

   // one avalon cycle; waits as long as the slave stalls, the bench timeout ends a hang
   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      avs_address_i   <= addr;
      avs_writedata_i <= wd;
      avs_write_i     <= wr;
      avs_read_i      <= !wr;
      do begin
         @(posedge core_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      rd_val = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      // an edge passes after release so no signal is set twice in one step
      @(posedge core_clk_i);
   endtask : bus

   task automatic wr(input logic [31:0] addr, input logic [15:0] wd);
      int i;
      i = (addr - `TCM_OFS_A_LOW) >> 2;
      bus(1'b1, addr, {16'h0000, wd});
      if (i <= 5) mdl[i] = wd;
      else if (i == 6 || i == 9) mdl[i] = {12'h000, wd[3:0]};
      else if (i == 7) ex_st = ex_st & ~wd[3:0];
   endtask : wr

   // status read returns flags, then drops the three match flags only
   task automatic rd_chk(input logic [31:0] addr);
      int          i;
      logic [31:0] ex;
      i  = (addr - `TCM_OFS_A_LOW) >> 2;
      ex = 32'h0000_0000;
      if (i == 7) ex = {28'h0000000, ex_st};
      else if (i <= 9 && i != 8) ex = {16'h0000, mdl[i]};
      bus(1'b0, addr, 32'h0000_0000);
      if (i == 7) ex_st = ex_st & 4'h8;
      cmp_reg(rd_val, ex);
   endtask : rd_chk

   task automatic chk_irq;
      repeat (3) @(posedge core_clk_i);
      cmp_flag(irq_o, |(ex_st & mdl[9][3:0]));
   endtask : chk_irq

   // model sets flags only on a fresh equality, as the design edge-detects
   task automatic cnt(input logic [31:0] v, input logic fr, input logic dn);
      int s;
      for (s = 0; s < 3; s++) begin
         if (mdl[6][s] && v != counter_value_i && v == {mdl[2*s+1], mdl[2*s]}) ex_st[s] = 1'b1;
      end
      if (mdl[6][3] && fr && v != counter_value_i && v == (dn ? 32'h0 : 32'hFFFF_FFFF))
         ex_st[3] = 1'b1;
      if (!fr && v != counter_value_i && v == {mdl[5], mdl[4]}) exp_reload++;
      counter_value_i <= v;
      free_run_i      <= fr;
      count_down_i    <= dn;
      repeat (4) @(posedge core_clk_i);
      cmp_flag(irq_o, |(ex_st & mdl[9][3:0]));
   endtask : cnt

   initial begin
      logic [31:0] a;
      logic [31:0] r;
      logic [31:0] t;
      int          s;
      int          d;
      mdl = '{16'h1FFF, 16'h0, 16'h2FFF, 16'h0, 16'h3FFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      // reset values, status, mask and two unmapped addresses
      for (a = `TCM_OFS_A_LOW; a <= 32'h4000_0038; a += 4) rd_chk(a);
      // random fill; software keeps the unused enable bits at zero
      for (a = `TCM_OFS_A_LOW; a <= `TCM_OFS_IEN; a += 4) begin
         r = $random(seed);
         wr(a, (a == `TCM_OFS_IEN) ? {12'h000, r[3:0]} : r[15:0]);
      end
      wr(32'h4000_0030, 16'hFFFF);
      for (a = `TCM_OFS_A_LOW; a <= 32'h4000_0038; a += 4) rd_chk(a);
      // each compare field: gated off, near misses, then a real match
      for (s = 0; s < 3; s++) begin
         r = $random(seed);
         wr(`TCM_OFS_IEN, 16'h0000);
         wr(`TCM_OFS_A_LOW + 8 * s, r[15:0]);
         wr(`TCM_OFS_A_HIGH + 8 * s, r[31:16]);
         wr(`TCM_OFS_MASK, (s != 1) ? (16'h1 << s) : 16'h0);
         cnt(r, 1'b1, 1'b0);
         cnt(IDLE_CNT, 1'b1, 1'b0);
         rd_chk(`TCM_OFS_STAT);
         wr(`TCM_OFS_IEN, 16'h1 << s);
         t = r ^ 32'h0001_0000;
         cnt(t, 1'b1, 1'b0);
         t = r ^ 32'h0000_0001;
         cnt(t, 1'b1, 1'b0);
         cnt(r, 1'b1, 1'b0);
         rd_chk(`TCM_OFS_STAT);
         chk_irq();
         rd_chk(`TCM_OFS_STAT);
         cnt(IDLE_CNT, 1'b1, 1'b0);
      end
      // rollover both directions, cleared by writing one
      wr(`TCM_OFS_IEN, 16'h0008);
      wr(`TCM_OFS_MASK, 16'h0008);
      for (d = 0; d < 2; d++) begin
         cnt(IDLE_CNT, 1'b1, d[0]);
         cnt(d[0] ? 32'h0 : 32'hFFFF_FFFF, 1'b1, d[0]);
         cnt(IDLE_CNT, 1'b1, d[0]);
         rd_chk(`TCM_OFS_STAT);
         wr(`TCM_OFS_STAT, 16'h0008);
         rd_chk(`TCM_OFS_STAT);
         chk_irq();
      end
      cnt(IDLE_CNT, 1'b0, 1'b0);
      cnt(32'hFFFF_FFFF, 1'b0, 1'b0);
      rd_chk(`TCM_OFS_STAT);
      // reload in periodic mode only, one pulse for a held equality
      r = $random(seed);
      wr(`TCM_OFS_IEN, 16'h0000);
      wr(`TCM_OFS_C_LOW, r[15:0]);
      wr(`TCM_OFS_C_HIGH, r[31:16]);
      cnt(IDLE_CNT, 1'b0, 1'b0);
      cnt(r, 1'b0, 1'b0);
      cnt(IDLE_CNT, 1'b1, 1'b0);
      cnt(r, 1'b1, 1'b0);
      cnt(IDLE_CNT, 1'b1, 1'b0);
      cmp_cnt(n_reload, exp_reload);
      test_done();
   end
endmodule : testbench
